// ### hw/ubt_defines.svh
// Timing constants of the UART bit-timing block.
`ifndef UBT_DEFINES_SVH
`define UBT_DEFINES_SVH
`define UBT_TICKS_PER_BIT 4'h0_F
`define UBT_HALF_BIT 4'h0_7
`define UBT_DATA_BITS 3'h7
`define UBT_DIV_W 16
`define UBT_DIV_DEFAULT 16'h0_005
`define UBT_LINE_IDLE 1'b1
// Enabled edges already counted when the stop bit is sampled on the next one.
`define UBT_STOP_AGE 8'h97
`define UBT_BUF_DEPTH 2
`endif

// ### hw/ubt_pkg.sv
// Types shared by the UART bit-timing block.
package ubt_pkg;
	typedef enum logic [1:0] {
		UBT_IDLE = 2'b00,
		UBT_START = 2'b01,
		UBT_DATA = 2'b11,
		UBT_STOP = 2'b10
	} ubt_state_t;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} ubt_byte_t;
endpackage : ubt_pkg

// ### hw/ubt_buf.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
`include "ubt_defines.svh"
module ubt_buf (
	input wire logic clk,
	input wire logic reset_n,
	input wire ubt_pkg::ubt_byte_t in_word,
	output logic in_ready,
	output ubt_pkg::ubt_byte_t out_word,
	input wire logic out_ready
);
	import ubt_pkg::*;
	logic [7:0] mem_reg [`UBT_BUF_DEPTH];
	logic [7:0] mem_next [`UBT_BUF_DEPTH];
	logic wptr_reg, wptr_next, rptr_reg, rptr_next;
	logic [1:0] cnt_reg, cnt_next;
	logic push, pop;
	always_comb begin
		push = in_word.valid && (cnt_reg != 2'h2);
		pop = out_ready && (cnt_reg != 2'h0);
		wptr_next = wptr_reg ^ push;
		rptr_next = rptr_reg ^ pop;
		cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
		mem_next = mem_reg;
		if (push) begin
			mem_next[wptr_reg] = in_word.data;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wptr_reg <= 1'b0;
			rptr_reg <= 1'b0;
			cnt_reg <= 2'h0;
			for (int i = 0; i < `UBT_BUF_DEPTH; i++) begin
				mem_reg[i] <= 8'h00;
			end
		end else begin
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
			cnt_reg <= cnt_next;
			mem_reg <= mem_next;
		end
	end
	always_comb begin
		in_ready = (cnt_reg != 2'h2);
		out_word.valid = (cnt_reg != 2'h0);
		out_word.data = mem_reg[rptr_reg];
	end
endmodule : ubt_buf
`default_nettype wire

// ### hw/ubt_top.sv
// UART bit timing: baud enable divider, transmitter and receiver.
`timescale 1ns/100ps
`default_nettype none
`include "ubt_defines.svh"
module ubt_top (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [`UBT_DIV_W-1:0] div_value,
	input wire logic div_load,
	input wire ubt_pkg::ubt_byte_t tx_word,
	output logic tx_ready,
	output logic serial_out,
	input wire logic serial_in,
	output ubt_pkg::ubt_byte_t rx_word,
	input wire logic rx_ready,
	output logic baud_en
);
	import ubt_pkg::*;

	// Baud enable divider.
	logic [`UBT_DIV_W-1:0] div_reg, div_next, dcnt_reg, dcnt_next;
	logic baud_en_next;
	always_comb begin
		div_next = div_load ? div_value : div_reg;
		dcnt_next = dcnt_reg + 16'h0001;
		baud_en_next = 1'b0;
		if (div_load) begin
			dcnt_next = 16'h0000;
		end else if (dcnt_reg >= div_reg) begin
			dcnt_next = 16'h0000;
			baud_en_next = 1'b1;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_reg <= `UBT_DIV_DEFAULT;
			dcnt_reg <= 16'h0000;
			baud_en <= 1'b0;
		end else begin
			div_reg <= div_next;
			dcnt_reg <= dcnt_next;
			baud_en <= baud_en_next;
		end
	end

	// Transmitter.
	ubt_state_t tx_st_reg, tx_st_next;
	logic [3:0] tx_tick_reg, tx_tick_next;
	logic [2:0] tx_bit_reg, tx_bit_next;
	logic [7:0] tx_sh_reg, tx_sh_next;
	logic tx_out_next, tx_ready_next;
	always_comb begin
		tx_st_next = tx_st_reg;
		tx_tick_next = tx_tick_reg;
		tx_bit_next = tx_bit_reg;
		tx_sh_next = tx_sh_reg;
		tx_out_next = serial_out;
		tx_ready_next = 1'b0;
		case (tx_st_reg)
			UBT_IDLE: begin
				tx_out_next = `UBT_LINE_IDLE;
				tx_ready_next = !tx_ready;
				if (tx_ready && tx_word.valid) begin
					tx_sh_next = tx_word.data;
					tx_tick_next = 4'h0;
					tx_out_next = 1'b0;
					tx_st_next = UBT_START;
					tx_ready_next = 1'b0;
				end
			end
			default: begin
				if (baud_en) begin
					tx_tick_next = tx_tick_reg + 4'h1;
					if (tx_tick_reg == `UBT_TICKS_PER_BIT) begin
						tx_tick_next = 4'h0;
						case (tx_st_reg)
							UBT_START: begin
								tx_st_next = UBT_DATA;
								tx_bit_next = 3'h0;
								tx_out_next = tx_sh_reg[0];
								tx_sh_next = {1'b0, tx_sh_reg[7:1]};
							end
							UBT_DATA: begin
								if (tx_bit_reg == `UBT_DATA_BITS) begin
									tx_st_next = UBT_STOP;
									tx_out_next = 1'b1;
								end else begin
									tx_bit_next = tx_bit_reg + 3'h1;
									tx_out_next = tx_sh_reg[0];
									tx_sh_next = {1'b0, tx_sh_reg[7:1]};
								end
							end
							default: begin
								tx_st_next = UBT_IDLE;
								tx_out_next = `UBT_LINE_IDLE;
							end
						endcase
					end
				end
			end
		endcase
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_st_reg <= UBT_IDLE;
			tx_tick_reg <= 4'h0;
			tx_bit_reg <= 3'h0;
			tx_sh_reg <= 8'h00;
			serial_out <= 1'b1;
			tx_ready <= 1'b0;
		end else begin
			tx_st_reg <= tx_st_next;
			tx_tick_reg <= tx_tick_next;
			tx_bit_reg <= tx_bit_next;
			tx_sh_reg <= tx_sh_next;
			serial_out <= tx_out_next;
			tx_ready <= tx_ready_next;
		end
	end

	// Receiver synchroniser; the first flop feeds only the second.
	logic sync1_reg, sync2_reg, prev_reg;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			prev_reg <= 1'b1;
		end else begin
			sync1_reg <= serial_in;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	ubt_state_t rx_st_reg, rx_st_next;
	logic [3:0] rx_tick_reg, rx_tick_next;
	logic [2:0] rx_bit_reg, rx_bit_next;
	logic [7:0] rx_sh_reg, rx_sh_next;
	ubt_byte_t rx_push;
	logic rx_in_ready;
	always_comb begin
		rx_st_next = rx_st_reg;
		rx_tick_next = rx_tick_reg;
		rx_bit_next = rx_bit_reg;
		rx_sh_next = rx_sh_reg;
		rx_push.valid = 1'b0;
		rx_push.data = rx_sh_reg;
		case (rx_st_reg)
			UBT_IDLE: begin
				if (prev_reg && !sync2_reg) begin
					rx_tick_next = 4'h0;
					rx_st_next = UBT_START;
				end
			end
			UBT_START: begin
				if (baud_en) begin
					rx_tick_next = rx_tick_reg + 4'h1;
					if (rx_tick_reg == `UBT_HALF_BIT) begin
						rx_tick_next = 4'h0;
						rx_bit_next = 3'h0;
						rx_st_next = sync2_reg ? UBT_IDLE : UBT_DATA;
					end
				end
			end
			UBT_DATA: begin
				if (baud_en) begin
					rx_tick_next = rx_tick_reg + 4'h1;
					if (rx_tick_reg == `UBT_TICKS_PER_BIT) begin
						rx_tick_next = 4'h0;
						rx_sh_next = {sync2_reg, rx_sh_reg[7:1]};
						rx_bit_next = rx_bit_reg + 3'h1;
						if (rx_bit_reg == `UBT_DATA_BITS) begin
							rx_st_next = UBT_STOP;
						end
					end
				end
			end
			default: begin
				if (baud_en) begin
					rx_tick_next = rx_tick_reg + 4'h1;
					if (rx_tick_reg == `UBT_TICKS_PER_BIT) begin
						rx_tick_next = 4'h0;
						rx_push.valid = sync2_reg && rx_in_ready;
						rx_st_next = UBT_IDLE;
					end
				end
			end
		endcase
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_st_reg <= UBT_IDLE;
			rx_tick_reg <= 4'h0;
			rx_bit_reg <= 3'h0;
			rx_sh_reg <= 8'h00;
		end else begin
			rx_st_reg <= rx_st_next;
			rx_tick_reg <= rx_tick_next;
			rx_bit_reg <= rx_bit_next;
			rx_sh_reg <= rx_sh_next;
		end
	end

	ubt_byte_t buf_out;
	ubt_buf u_buf (
		.clk(clk),
		.reset_n(reset_n),
		.in_word(rx_push),
		.in_ready(rx_in_ready),
		.out_word(buf_out),
		.out_ready(rx_ready && rx_word.valid)
	);
	// The buffer head is re-registered; a pop takes effect as the word leaves.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_word <= '0;
		end else begin
			rx_word <= (rx_ready && rx_word.valid) ? '0 : buf_out;
		end
	end

	// Counts enabled edges of a receive character from the falling edge.
	logic [7:0] rx_age_reg;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_age_reg <= 8'h00;
		end else if (rx_st_reg == UBT_IDLE) begin
			rx_age_reg <= 8'h00;
		end else if (baud_en) begin
			rx_age_reg <= rx_age_reg + 8'h01;
		end
	end

	chk_stop_sample_point: assert property (@(posedge clk) disable iff (!reset_n)
		(rx_st_reg == UBT_STOP && rx_st_next == UBT_IDLE) |-> rx_age_reg == `UBT_STOP_AGE)
		else $error("stop bit not sampled at 152 enables");
	chk_glitch_reject: assert property (@(posedge clk) disable iff (!reset_n)
		(rx_st_reg == UBT_START && baud_en && rx_tick_reg == `UBT_HALF_BIT && sync2_reg)
		|=> rx_st_reg == UBT_IDLE)
		else $error("start glitch not rejected");
	chk_tx_idle_high: assert property (@(posedge clk) disable iff (!reset_n)
		$past(tx_st_reg) == UBT_IDLE && tx_st_reg == UBT_IDLE |-> serial_out)
		else $error("serial output low while idle");
	chk_baud_one_cycle: assert property (@(posedge clk) disable iff (!reset_n)
		baud_en && div_reg != 16'h0000 |=> !baud_en)
		else $error("enable wider than one cycle");
	chk_tx_start_low: assert property (@(posedge clk) disable iff (!reset_n)
		tx_st_reg == UBT_START |-> !serial_out)
		else $error("start bit not low");
	chk_tx_hold_bit: assert property (@(posedge clk) disable iff (!reset_n)
		!baud_en && tx_st_reg != UBT_IDLE |=> $stable(serial_out) && $stable(tx_tick_reg))
		else $error("transmit timing moved without enable");
	chk_bad_stop_drop: assert property (@(posedge clk) disable iff (!reset_n)
		(rx_st_reg == UBT_STOP && !sync2_reg) |-> !rx_push.valid)
		else $error("character with low stop bit kept");
	chk_edge_restart: assert property (@(posedge clk) disable iff (!reset_n)
		(rx_st_reg == UBT_IDLE && prev_reg && !sync2_reg) |=> rx_tick_reg == 4'h0
		&& rx_st_reg == UBT_START)
		else $error("receiver timing not restarted at edge");
	// A data bit is taken on the sixteenth enabled edge of its bit period.
	sequence s_rx_data_sample;
		rx_st_reg == UBT_DATA && baud_en && rx_tick_reg == `UBT_TICKS_PER_BIT;
	endsequence
	chk_rx_bit_step: assert property (@(posedge clk) disable iff (!reset_n)
		s_rx_data_sample |=> rx_tick_reg == 4'h0 && rx_sh_reg[7] == $past(sync2_reg))
		else $error("data bit not sampled on sixteenth enable");
endmodule : ubt_top
`default_nettype wire

// ### tb/ubt_remote.sv
// Remote UART model that drives and watches the serial line.
`timescale 1ns/100ps
`default_nettype none
module ubt_remote (
	input wire logic clk,
	input wire logic line_in,
	output logic line_out
);
	initial begin
		line_out = 1'b1;
	end
	// Sends one 8N1 frame with no flow control, each bit held len clocks.
	task automatic send(input logic [7:0] d, input logic stop, input int len);
		logic [9:0] f;
		f = {stop, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clk);
			line_out = f[i];
			repeat (len - 1) @(negedge clk);
		end
		@(negedge clk);
		line_out = 1'b1;
	endtask : send
	// Captures a frame at bit centres, starting from the falling edge.
	task automatic recv(output logic [9:0] f, input int len);
		while (line_in !== 1'b0) @(negedge clk);
		repeat (len / 2) @(negedge clk);
		for (int i = 0; i < 10; i++) begin
			f[i] = line_in;
			repeat (len) @(negedge clk);
		end
	endtask : recv
endmodule : ubt_remote
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the UART bit-timing block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import ubt_pkg::*;
	localparam int BIT = 96;
	logic clk;
	logic reset_n;
	logic [15:0] div_value;
	logic div_load;
	ubt_byte_t tx_word;
	ubt_byte_t rx_word;
	logic tx_ready;
	logic serial_out;
	logic serial_in;
	logic rx_ready;
	logic baud_en;
	int fail_count = 0;
	int n_compared = 0;
	ubt_top u_dut (.clk(clk), .reset_n(reset_n), .div_value(div_value),
		.div_load(div_load), .tx_word(tx_word), .tx_ready(tx_ready),
		.serial_out(serial_out), .serial_in(serial_in), .rx_word(rx_word),
		.rx_ready(rx_ready), .baud_en(baud_en));
	ubt_remote u_rem (.clk(clk), .line_in(serial_out), .line_out(serial_in));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// Loads a divider value and measures the spacing of enable pulses.
	task automatic gap(input logic [15:0] v, input int exp);
		int n;
		div_value = v;
		div_load = 1'b1;
		@(negedge clk);
		div_load = 1'b0;
		n = 0;
		while (baud_en !== 1'b1) @(negedge clk);
		@(negedge clk);
		while (baud_en !== 1'b1) begin
			n++;
			@(negedge clk);
		end
		cmp(10'(n + 1), 10'(exp));
	endtask : gap
	task automatic t_tx(input logic [7:0] d, input int len);
		logic [9:0] f;
		fork
			u_rem.recv(f, len);
			begin
				// Ready seen at a falling edge means the next rising edge takes the byte.
				tx_word = '{1'b1, d};
				while (tx_ready !== 1'b1) @(negedge clk);
				@(negedge clk);
				tx_word = '{1'b0, 8'h00};
			end
		join
		cmp(f, {1'b1, d, 1'b0});
	endtask : t_tx
	// Waits briefly for a received word and consumes it if one is expected.
	task automatic pop(input logic ok, input logic [7:0] d);
		repeat (20) if (rx_word.valid !== 1'b1) @(negedge clk);
		cmp(10'(rx_word.valid), 10'(ok));
		if (ok) begin
			cmp(10'(rx_word.data), 10'(d));
			rx_ready = 1'b1;
			@(negedge clk);
			rx_ready = 1'b0;
			@(negedge clk);
		end
	endtask : pop
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		end_of_test();
	end
	initial begin
		reset_n = 1'b0;
		div_value = 16'h0005;
		div_load = 1'b0;
		tx_word = '0;
		rx_ready = 1'b0;
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		repeat (2) @(negedge clk);
		cmp(10'(serial_out), 10'h001);
		gap(16'h0002, 3);
		gap(16'h0000, 1);
		gap(16'h0005, 6);
		t_tx(8'hA5, BIT);
		t_tx(8'h01, BIT);
		cmp(10'(serial_out), 10'h001);
		u_rem.send(8'h3C, 1'b1, BIT);
		pop(1'b1, 8'h3C);
		u_rem.send(8'hFF, 1'b1, 24);
		repeat (1000) @(negedge clk);
		pop(1'b0, 8'h00);
		u_rem.send(8'h55, 1'b0, BIT);
		pop(1'b0, 8'h00);
		u_rem.send(8'h11, 1'b1, BIT);
		u_rem.send(8'h22, 1'b1, BIT);
		u_rem.send(8'h33, 1'b1, BIT);
		pop(1'b1, 8'h11);
		pop(1'b1, 8'h22);
		pop(1'b0, 8'h00);
		gap(16'h0000, 1);
		t_tx(8'h96, 16);
		u_rem.send(8'h5A, 1'b1, 16);
		pop(1'b1, 8'h5A);
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
